// ### rtl/serial_port_defs.svh
/*
 * Constants of the serial port: characters, buffer sizes, pacing thresholds, timing.
 * Assumes a 100 MHz system clock and a 16x oversampled bit period.
 */
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH

`define CLK_HZ          100000000
`define OVERSAMPLE      16
`define BAUD_DIV(b)     ((`CLK_HZ) / ((`OVERSAMPLE) * (b)))

`define BAUD_150        150
`define BAUD_300        300
`define BAUD_600        600
`define BAUD_1200       1200
`define BAUD_2400       2400
`define BAUD_4800       4800
`define BAUD_9600       9600
`define BAUD_19200      19200

`define CHAR_GO         8'h11
`define CHAR_STOP       8'h13

`define RXBUF_DEPTH     2000
`define RXBUF_LAST      11'h7cf
`define RXBUF_HIGH      11'h790
`define RXBUF_LOW       11'h400

`define TXFIFO_WIDTH    8
`define TXFIFO_DEPTH    32

`define TICK_MID        4'h7
`define TICK_LAST       4'hf

`endif

// ### rtl/serial_port_pkg.sv
/*
 * Types of the serial port: configuration carrier and state machine enums.
 * Assumes the configuration is held in storage outside, untouched by reset.
 */
package serial_port_pkg;

    typedef enum logic [2:0] {
        BAUD_SEL_150, BAUD_SEL_300, BAUD_SEL_600, BAUD_SEL_1200,
        BAUD_SEL_2400, BAUD_SEL_4800, BAUD_SEL_9600, BAUD_SEL_19200
    } baud_sel_t;

    typedef enum logic [2:0] {
        PAR_NONE, PAR_ODD, PAR_EVEN, PAR_ONE, PAR_ZERO
    } parity_mode_t;

    typedef struct packed {
        baud_sel_t    baud;
        parity_mode_t parity;
        logic         eight_bits;
        logic         two_stop;
        logic         rx_pace;
        logic         tx_pace;
        logic         route_cmd_line;
        logic         inst_echo;
        logic         program_output_echo;
    } serial_cfg_t;

    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP
    } rx_state_t;

    typedef enum logic [2:0] {
        TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP
    } tx_state_t;

endpackage : serial_port_pkg

// ### rtl/char_fifo.sv
/*
 * Character FIFO with valid/ready on both sides; width and depth are parameters.
 * Assumes one clock; read data is valid whenever out_valid_out is high.
 */
`timescale 1ns/1ps
module char_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_sys_in,
    input  wire logic             nrst_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    output logic [WIDTH-1:0]      out_data_out,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [CW-1:0] count;
        logic          full;
        logic          empty;
    } fifo_state_t;

    fifo_state_t      st_ff;
    fifo_state_t      nxt_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    assign push = in_valid_in & ~st_ff.full;
    assign pop  = out_ready_in & ~st_ff.empty;

    always_comb
    begin
        nxt_st = st_ff;
        if (push)
        begin
            nxt_st.wr_ptr = (st_ff.wr_ptr == PW'(DEPTH - 1)) ? '0 : st_ff.wr_ptr + 1'b1;
        end
        if (pop)
        begin
            nxt_st.rd_ptr = (st_ff.rd_ptr == PW'(DEPTH - 1)) ? '0 : st_ff.rd_ptr + 1'b1;
        end
        if (push && !pop)
        begin
            nxt_st.count = st_ff.count + 1'b1;
        end
        else if (pop && !push)
        begin
            nxt_st.count = st_ff.count - 1'b1;
        end
        nxt_st.full  = (nxt_st.count == CW'(DEPTH));
        nxt_st.empty = (nxt_st.count == '0);
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            st_ff <= '{wr_ptr: '0, rd_ptr: '0, count: '0, full: 1'b0, empty: 1'b1};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (push)
        begin
            mem[st_ff.wr_ptr] <= in_data_in;
        end
    end

    assign in_ready_out  = ~st_ff.full;
    assign out_valid_out = ~st_ff.empty;
    assign out_data_out  = mem[st_ff.rd_ptr];

endmodule : char_fifo

// ### rtl/serial_port_uart.sv
/*
 * Three-wire serial port with software pacing, receive buffer, command line
 * routing and echo paths.
 * Assumes cfg_in comes from settings storage that no reset touches, and that
 * rxd_in is asynchronous to clk_sys_in.
 */
`timescale 1ns/1ps
`include "serial_port_defs.svh"
module serial_port_uart (
    input  wire logic                        clk_sys_in,
    input  wire logic                        nrst_in,
    input  wire serial_port_pkg::serial_cfg_t cfg_in,
    input  wire logic                        rxd_in,
    output logic                             txd_out,
    input  wire logic                        rd_req_in,
    output logic [7:0]                       rd_data_out,
    output logic                             rd_valid_out,
    output logic [10:0]                      rx_count_out,
    output logic [7:0]                       cmd_char_out,
    output logic                             cmd_valid_out,
    input  wire logic [7:0]                  prog_char_in,
    input  wire logic                        prog_valid_in,
    output logic                             prog_ready_out,
    output logic                             parity_err_out,
    output logic                             frame_err_out,
    output logic                             overrun_out,
    output logic                             tx_halted_out
);
    typedef struct packed {
        logic                       rxd_meta;
        logic                       rxd_sync;
        logic [15:0]                div_cnt;
        logic                       tick;
        serial_port_pkg::rx_state_t rx_st;
        logic [3:0]                 rx_tick;
        logic [2:0]                 rx_bit;
        logic [7:0]                 rx_shift;
        logic                       rx_par;
        serial_port_pkg::tx_state_t tx_st;
        logic [3:0]                 tx_tick;
        logic [2:0]                 tx_bit;
        logic [7:0]                 tx_shift;
        logic                       tx_par;
        logic                       txd;
        logic                       halted;
        logic                       stop_sent;
        logic                       ctl_pend;
        logic [7:0]                 ctl_char;
        logic                       echo_pend;
        logic [7:0]                 echo_char;
        logic [10:0]                wr_ptr;
        logic [10:0]                rd_ptr;
        logic [10:0]                count;
        logic                       rd_valid;
        logic [7:0]                 cmd_char;
        logic                       cmd_valid;
        logic                       parity_err;
        logic                       frame_err;
        logic                       overrun;
    } port_state_t;

    port_state_t st_ff;
    port_state_t nxt_st;
    logic [7:0]  rxbuf [`RXBUF_DEPTH];
    logic [7:0]  rd_data_ff;
    logic        buf_wr;
    logic        buf_rd;
    logic [7:0]  rx_char;
    logic [15:0] baud_div;
    logic        fifo_valid;
    logic [7:0]  fifo_data;
    logic        fifo_pop;
    logic        fifo_ready;

    function automatic logic parity_of(input serial_port_pkg::parity_mode_t mode,
                                       input logic [7:0] data, input logic eight);
        logic [7:0] d;
        d = eight ? data : {1'b0, data[6:0]};
        case (mode)
            serial_port_pkg::PAR_ODD:  parity_of = ~^d;
            serial_port_pkg::PAR_EVEN: parity_of = ^d;
            serial_port_pkg::PAR_ONE:  parity_of = 1'b1;
            default:                   parity_of = 1'b0;
        endcase
    endfunction : parity_of

    // program output only enters the queue while its echo is enabled
    char_fifo #(
        .WIDTH (`TXFIFO_WIDTH),
        .DEPTH (`TXFIFO_DEPTH)
    ) u_tx_fifo (
        .clk_sys_in    (clk_sys_in),
        .nrst_in       (nrst_in),
        .in_data_in    (prog_char_in),
        .in_valid_in   (prog_valid_in & cfg_in.program_output_echo),
        .in_ready_out  (fifo_ready),
        .out_data_out  (fifo_data),
        .out_valid_out (fifo_valid),
        .out_ready_in  (fifo_pop)
    );

    always_comb
    begin
        case (cfg_in.baud)
            serial_port_pkg::BAUD_SEL_150:   baud_div = 16'(`BAUD_DIV(`BAUD_150));
            serial_port_pkg::BAUD_SEL_300:   baud_div = 16'(`BAUD_DIV(`BAUD_300));
            serial_port_pkg::BAUD_SEL_600:   baud_div = 16'(`BAUD_DIV(`BAUD_600));
            serial_port_pkg::BAUD_SEL_1200:  baud_div = 16'(`BAUD_DIV(`BAUD_1200));
            serial_port_pkg::BAUD_SEL_2400:  baud_div = 16'(`BAUD_DIV(`BAUD_2400));
            serial_port_pkg::BAUD_SEL_4800:  baud_div = 16'(`BAUD_DIV(`BAUD_4800));
            serial_port_pkg::BAUD_SEL_9600:  baud_div = 16'(`BAUD_DIV(`BAUD_9600));
            default:                         baud_div = 16'(`BAUD_DIV(`BAUD_19200));
        endcase
    end

    always_comb
    begin
        nxt_st = st_ff;
        buf_wr = 1'b0;
        buf_rd = 1'b0;
        fifo_pop = 1'b0;
        rx_char = cfg_in.eight_bits ? st_ff.rx_shift : {1'b0, st_ff.rx_shift[7:1]};
        nxt_st.rd_valid   = 1'b0;
        nxt_st.cmd_valid  = 1'b0;
        nxt_st.parity_err = 1'b0;
        nxt_st.frame_err  = 1'b0;
        nxt_st.overrun    = 1'b0;

        nxt_st.rxd_meta = rxd_in;
        nxt_st.rxd_sync = st_ff.rxd_meta;

        // one oversample tick per 16th of a bit
        nxt_st.tick = 1'b0;
        if (st_ff.div_cnt >= baud_div - 16'h0001)
        begin
            nxt_st.div_cnt = 16'h0000;
            nxt_st.tick = 1'b1;
        end
        else
        begin
            nxt_st.div_cnt = st_ff.div_cnt + 16'h0001;
        end

        // receiver: sample mid-bit, 16 ticks per bit after start confirm
        case (st_ff.rx_st)
            serial_port_pkg::RX_IDLE:
            begin
                nxt_st.rx_tick = 4'h0;
                if (!st_ff.rxd_sync)
                begin
                    nxt_st.rx_st = serial_port_pkg::RX_START;
                end
            end
            serial_port_pkg::RX_START:
            begin
                if (st_ff.tick)
                begin
                    nxt_st.rx_tick = st_ff.rx_tick + 4'h1;
                    if (st_ff.rx_tick == `TICK_MID)
                    begin
                        nxt_st.rx_tick = 4'h0;
                        nxt_st.rx_bit = 3'h0;
                        // a glitch shorter than half a bit is not a start
                        nxt_st.rx_st = st_ff.rxd_sync ? serial_port_pkg::RX_IDLE
                                                      : serial_port_pkg::RX_DATA;
                    end
                end
            end
            serial_port_pkg::RX_DATA:
            begin
                if (st_ff.tick)
                begin
                    nxt_st.rx_tick = st_ff.rx_tick + 4'h1;
                    if (st_ff.rx_tick == `TICK_LAST)
                    begin
                        nxt_st.rx_shift = {st_ff.rxd_sync, st_ff.rx_shift[7:1]};
                        nxt_st.rx_bit = st_ff.rx_bit + 3'h1;
                        if (st_ff.rx_bit == {2'b11, cfg_in.eight_bits})
                        begin
                            nxt_st.rx_st = (cfg_in.parity == serial_port_pkg::PAR_NONE)
                                         ? serial_port_pkg::RX_STOP
                                         : serial_port_pkg::RX_PARITY;
                        end
                    end
                end
            end
            serial_port_pkg::RX_PARITY:
            begin
                if (st_ff.tick)
                begin
                    nxt_st.rx_tick = st_ff.rx_tick + 4'h1;
                    if (st_ff.rx_tick == `TICK_LAST)
                    begin
                        nxt_st.rx_par = st_ff.rxd_sync;
                        nxt_st.rx_st = serial_port_pkg::RX_STOP;
                    end
                end
            end
            serial_port_pkg::RX_STOP:
            begin
                if (st_ff.tick)
                begin
                    nxt_st.rx_tick = st_ff.rx_tick + 4'h1;
                    if (st_ff.rx_tick == `TICK_LAST)
                    begin
                        nxt_st.rx_st = serial_port_pkg::RX_IDLE;
                        if (!st_ff.rxd_sync)
                        begin
                            nxt_st.frame_err = 1'b1;
                        end
                        else if (cfg_in.parity != serial_port_pkg::PAR_NONE &&
                                 st_ff.rx_par != parity_of(cfg_in.parity, rx_char,
                                                           cfg_in.eight_bits))
                        begin
                            nxt_st.parity_err = 1'b1;
                        end
                        else if (cfg_in.tx_pace && rx_char == `CHAR_STOP)
                        begin
                            nxt_st.halted = 1'b1;
                        end
                        else if (cfg_in.tx_pace && rx_char == `CHAR_GO)
                        begin
                            nxt_st.halted = 1'b0;
                        end
                        else
                        begin
                            // a second echo before the first leaves overwrites it
                            if (cfg_in.inst_echo)
                            begin
                                nxt_st.echo_pend = 1'b1;
                                nxt_st.echo_char = rx_char;
                            end
                            if (cfg_in.route_cmd_line)
                            begin
                                nxt_st.cmd_valid = 1'b1;
                                nxt_st.cmd_char = rx_char;
                            end
                            else if (st_ff.count != 11'(`RXBUF_DEPTH))
                            begin
                                buf_wr = 1'b1;
                            end
                            else
                            begin
                                nxt_st.overrun = 1'b1;
                            end
                        end
                    end
                end
            end
            default:
            begin
                nxt_st.rx_st = serial_port_pkg::RX_IDLE;
            end
        endcase

        // receive buffer; a program may read back to back, one char per cycle
        if (buf_wr)
        begin
            nxt_st.wr_ptr = (st_ff.wr_ptr == `RXBUF_LAST) ? 11'h000 : st_ff.wr_ptr + 11'h001;
        end
        if (rd_req_in && st_ff.count != 11'h000)
        begin
            buf_rd = 1'b1;
            nxt_st.rd_valid = 1'b1;
            nxt_st.rd_ptr = (st_ff.rd_ptr == `RXBUF_LAST) ? 11'h000 : st_ff.rd_ptr + 11'h001;
        end
        nxt_st.count = st_ff.count + 11'(buf_wr) - 11'(buf_rd);

        // receive pacing; with pacing off no flow characters go out
        if (!cfg_in.rx_pace)
        begin
            nxt_st.stop_sent = 1'b0;
        end
        else if (!st_ff.ctl_pend && !st_ff.stop_sent && st_ff.count >= `RXBUF_HIGH)
        begin
            nxt_st.ctl_pend = 1'b1;
            nxt_st.ctl_char = `CHAR_STOP;
            nxt_st.stop_sent = 1'b1;
        end
        else if (!st_ff.ctl_pend && st_ff.stop_sent && st_ff.count <= `RXBUF_LOW)
        begin
            nxt_st.ctl_pend = 1'b1;
            nxt_st.ctl_char = `CHAR_GO;
            nxt_st.stop_sent = 1'b0;
        end

        // transmitter; flow characters pass a halt, data does not
        case (st_ff.tx_st)
            serial_port_pkg::TX_IDLE:
            begin
                nxt_st.txd = 1'b1;
                nxt_st.tx_tick = 4'h0;
                nxt_st.tx_bit = 3'h0;
                if (st_ff.ctl_pend && st_ff.tick)
                begin
                    nxt_st.ctl_pend = 1'b0;
                    nxt_st.tx_shift = st_ff.ctl_char;
                    nxt_st.tx_st = serial_port_pkg::TX_START;
                end
                else if (!(st_ff.halted && cfg_in.tx_pace) && st_ff.tick)
                begin
                    if (st_ff.echo_pend)
                    begin
                        nxt_st.echo_pend = 1'b0;
                        nxt_st.tx_shift = st_ff.echo_char;
                        nxt_st.tx_st = serial_port_pkg::TX_START;
                    end
                    else if (fifo_valid)
                    begin
                        fifo_pop = 1'b1;
                        nxt_st.tx_shift = fifo_data;
                        nxt_st.tx_st = serial_port_pkg::TX_START;
                    end
                end
                nxt_st.tx_par = parity_of(cfg_in.parity, nxt_st.tx_shift, cfg_in.eight_bits);
            end
            serial_port_pkg::TX_START:
            begin
                nxt_st.txd = 1'b0;
                if (st_ff.tick)
                begin
                    nxt_st.tx_tick = st_ff.tx_tick + 4'h1;
                    if (st_ff.tx_tick == `TICK_LAST)
                    begin
                        nxt_st.txd = st_ff.tx_shift[0];
                        nxt_st.tx_st = serial_port_pkg::TX_DATA;
                    end
                end
            end
            serial_port_pkg::TX_DATA:
            begin
                if (st_ff.tick)
                begin
                    nxt_st.tx_tick = st_ff.tx_tick + 4'h1;
                    if (st_ff.tx_tick == `TICK_LAST)
                    begin
                        nxt_st.tx_shift = {1'b0, st_ff.tx_shift[7:1]};
                        nxt_st.tx_bit = st_ff.tx_bit + 3'h1;
                        nxt_st.txd = st_ff.tx_shift[1];
                        if (st_ff.tx_bit == {2'b11, cfg_in.eight_bits})
                        begin
                            nxt_st.tx_bit = 3'h0;
                            if (cfg_in.parity == serial_port_pkg::PAR_NONE)
                            begin
                                nxt_st.txd = 1'b1;
                                nxt_st.tx_st = serial_port_pkg::TX_STOP;
                            end
                            else
                            begin
                                nxt_st.txd = st_ff.tx_par;
                                nxt_st.tx_st = serial_port_pkg::TX_PARITY;
                            end
                        end
                    end
                end
            end
            serial_port_pkg::TX_PARITY:
            begin
                if (st_ff.tick)
                begin
                    nxt_st.tx_tick = st_ff.tx_tick + 4'h1;
                    if (st_ff.tx_tick == `TICK_LAST)
                    begin
                        nxt_st.txd = 1'b1;
                        nxt_st.tx_st = serial_port_pkg::TX_STOP;
                    end
                end
            end
            serial_port_pkg::TX_STOP:
            begin
                nxt_st.txd = 1'b1;
                if (st_ff.tick)
                begin
                    nxt_st.tx_tick = st_ff.tx_tick + 4'h1;
                    if (st_ff.tx_tick == `TICK_LAST)
                    begin
                        nxt_st.tx_bit = 3'h1;
                        if (!cfg_in.two_stop || st_ff.tx_bit != 3'h0)
                        begin
                            nxt_st.tx_st = serial_port_pkg::TX_IDLE;
                        end
                    end
                end
            end
            default:
            begin
                nxt_st.tx_st = serial_port_pkg::TX_IDLE;
            end
        endcase
    end

    // reset clears only transport state; cfg_in is never stored here
    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            st_ff <= '0;
            st_ff.rxd_meta <= 1'b1;
            st_ff.rxd_sync <= 1'b1;
            st_ff.txd <= 1'b1;
            st_ff.rx_st <= serial_port_pkg::RX_IDLE;
            st_ff.tx_st <= serial_port_pkg::TX_IDLE;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (buf_wr)
        begin
            rxbuf[st_ff.wr_ptr] <= rx_char;
        end
        if (buf_rd)
        begin
            rd_data_ff <= rxbuf[st_ff.rd_ptr];
        end
    end

    assign txd_out        = st_ff.txd;
    assign rd_data_out    = rd_data_ff;
    assign rd_valid_out   = st_ff.rd_valid;
    assign rx_count_out   = st_ff.count;
    assign cmd_char_out   = st_ff.cmd_char;
    assign cmd_valid_out  = st_ff.cmd_valid;
    assign prog_ready_out = fifo_ready;
    assign parity_err_out = st_ff.parity_err;
    assign frame_err_out  = st_ff.frame_err;
    assign overrun_out    = st_ff.overrun;
    assign tx_halted_out  = st_ff.halted;

endmodule : serial_port_uart

// ### verif/serial_port_checker.sv
/* port checks of serial_port_uart.
   assumes it is bound onto every serial_port_uart. */
`timescale 1ns/1ps
module serial_port_checker (
    input wire logic                         clk_sys_in,
    input wire logic                         nrst_in,
    input wire serial_port_pkg::serial_cfg_t cfg_in,
    input wire logic                         txd_out,
    input wire logic                         rd_req_in,
    input wire logic                         rd_valid_out,
    input wire logic [10:0]                  rx_count_out,
    input wire logic                         cmd_valid_out,
    input wire logic                         tx_halted_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    chk_read_answer: assert property (rd_req_in && rx_count_out != 11'h0 |=> rd_valid_out)
        else $error("read not answered");
    chk_read_cause: assert property (rd_valid_out |-> $past(rd_req_in) && $past(rx_count_out) != 11'h0)
        else $error("read pulse without request");
    chk_read_empty: assert property (rd_req_in && rx_count_out == 11'h0 |=> !rd_valid_out)
        else $error("read of empty buffer answered");
    chk_buffer_bound: assert property (rx_count_out <= 11'd2000)
        else $error("buffer count above capacity");
    chk_reset_idle: assert property ($rose(nrst_in) |-> txd_out && !rd_valid_out && !cmd_valid_out)
        else $error("outputs not idle after reset");
    chk_start_bit: assert property ($fell(txd_out) |-> !txd_out [*8])
        else $error("start bit too short");
    chk_cmd_route: assert property (cmd_valid_out |-> cfg_in.route_cmd_line)
        else $error("command char while routed to program");
    chk_halt_pace: assert property ($rose(tx_halted_out) |-> cfg_in.tx_pace)
        else $error("halt without transmit pacing");
    cover property (rd_valid_out);
    cover property ($fell(txd_out));
    cover property (rx_count_out == 11'd1);
endmodule : serial_port_checker

bind serial_port_uart serial_port_checker i_serial_port_checker (.clk_sys_in, .nrst_in,
    .cfg_in, .txd_out, .rd_req_in, .rd_valid_out, .rx_count_out, .cmd_valid_out, .tx_halted_out);

// ### verif/term_model.sv
/* terminal model: 8N1 frames at 19200 baud both ways.
   assumes a 100 MHz clock; line idles high. */
`timescale 1ns/1ps
module term_model (
    input  wire logic  clk_sys_in,
    input  wire logic  txd_in,
    output logic       rxd_out,
    output logic [7:0] got_out,
    output logic       got_stb_out
);
    localparam int BIT = 5200;
    initial
    begin
        rxd_out = 1'b1;
        got_out = 8'h00;
        got_stb_out = 1'b0;
    end
    task automatic send(input logic [7:0] c);
        for (int i = 0; i < 10; i++)
        begin
            rxd_out <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : c[i-1];
            repeat (BIT) @(posedge clk_sys_in);
        end
    endtask : send
    // sample mid-bit so a few cycles of skew cannot flip a bit
    always
    begin
        @(negedge txd_in);
        repeat (BIT / 2) @(posedge clk_sys_in);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT) @(posedge clk_sys_in);
            got_out[i] <= txd_in;
        end
        got_stb_out <= 1'b1;
        @(posedge clk_sys_in);
        got_stb_out <= 1'b0;
        repeat (BIT) @(posedge clk_sys_in);
    end
endmodule : term_model

// ### verif/test_serial_port_uart.sv
/* testbench of serial_port_uart with a terminal model.
   assumes 19200 baud, so one frame is about 52000 cycles. */
`timescale 1ns/1ps
`include "serial_port_defs.svh"
module test_serial_port_uart;
    logic clk_sys_in, nrst_in, rxd, txd, rd_req_in, rd_valid_out;
    logic prog_valid_in, prog_ready_out, got_stb, halt;
    logic [7:0] rd_data_out, prog_char_in, got, c, p;
    logic [10:0] rx_count_out;
    serial_port_pkg::serial_cfg_t cfg_in;
    logic [7:0] exp_rd[$], exp_tx[$];
    int fails = 0, comparisons = 0;
    serial_port_uart i_serial_port_uart (.clk_sys_in, .nrst_in, .cfg_in, .rxd_in(rxd),
        .txd_out(txd), .rd_req_in, .rd_data_out, .rd_valid_out, .rx_count_out,
        .cmd_char_out(), .cmd_valid_out(), .prog_char_in, .prog_valid_in, .prog_ready_out,
        .parity_err_out(), .frame_err_out(), .overrun_out(), .tx_halted_out(halt));
    term_model i_term_model (.clk_sys_in, .txd_in(txd), .rxd_out(rxd), .got_out(got),
        .got_stb_out(got_stb));
    task automatic cmp(input logic [10:0] g, input logic [10:0] e);
        comparisons++;
        if (g !== e)
        begin
            fails++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask : cmp
    task automatic summarize;
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    // an unexpected pulse meets an empty queue and compares against 7ff
    always @(posedge clk_sys_in)
    begin
        if (rd_valid_out === 1'b1)
            cmp(rd_data_out, exp_rd.size() ? exp_rd.pop_front() : 11'h7ff);
        if (got_stb === 1'b1)
            cmp(got, exp_tx.size() ? exp_tx.pop_front() : 11'h7ff);
    end
    initial
    begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    initial
    begin
        #1100us;
        fails++;
        summarize();
    end
    initial
    begin
        nrst_in = 1'b0;
        rd_req_in = 1'b0;
        prog_valid_in = 1'b0;
        prog_char_in = 8'h00;
        cfg_in = '{serial_port_pkg::BAUD_SEL_19200, serial_port_pkg::PAR_NONE,
            1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
        void'($urandom(32'hcc4e));
        repeat (4) @(posedge clk_sys_in);
        #1 nrst_in = 1'b1;
        @(posedge clk_sys_in);
        #1 rd_req_in = 1'b1;
        @(posedge clk_sys_in);
        #1 rd_req_in = 1'b0;
        $display("test empty read done");
        // printable range keeps the flow characters out of the data
        c = 8'h20 + 8'($urandom % 96);
        p = 8'h20 + 8'($urandom % 96);
        exp_tx.push_back(p);
        fork
            i_term_model.send(c);
            begin
                prog_char_in = p;
                prog_valid_in = 1'b1;
                do @(posedge clk_sys_in); while (prog_ready_out !== 1'b1);
                #1 prog_valid_in = 1'b0;
            end
        join
        cmp(rx_count_out, 11'd1);
        exp_rd.push_back(c);
        @(posedge clk_sys_in);
        #1 rd_req_in = 1'b1;
        @(posedge clk_sys_in);
        #1 rd_req_in = 1'b0;
        repeat (3) @(posedge clk_sys_in);
        cmp(rx_count_out, 11'd0);
        $display("test buffered read done");
        for (int i = 0; i < 20000 && exp_tx.size() != 0; i++) @(posedge clk_sys_in);
        cmp(11'(exp_tx.size() + exp_rd.size()), 11'd0);
        $display("test program echo done");
        // a stop char from the partner paces the transmitter and is not stored
        i_term_model.send(`CHAR_STOP);
        cmp(11'(halt), 11'h001);
        cmp(rx_count_out, 11'h000);
        $display("test transmit pacing done");
        summarize();
    end
endmodule : test_serial_port_uart
